//--- core_ctrl_model.sv
// Behavioural stand-in for the core's side of the control register path.
// Assumes the map forwards one access per valid pulse on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module core_ctrl_model
  import mem_map_pkg::*;
(
  input wire logic clk_sys,             // Core clock
  input wire logic nrst,                // Synchronous reset, active low
  input wire ctrl_acc_t acc,            // Forwarded control access
  output logic [DADDR_W-1:0] last_addr, // Address of the latest access
  output logic [DATA_W-1:0] last_wdata  // Data of the latest write
);
  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  // The core owns these registers, so it only records what reached it.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      last_addr <= '0;
      last_wdata <= '0;
    end else if (acc.valid) begin
      last_addr <= acc.addr;
      if (acc.write) begin
        last_wdata <= acc.wdata;
      end
    end
  end
endmodule
`default_nettype wire

//--- data_addr_decode.sv
// Decodes a full data address into control, scratch or unimplemented space.
// Purely combinational; the caller holds the scratch store.
`timescale 1ns/1ps
`default_nettype none
module data_addr_decode
  import mem_map_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic [DADDR_W-1:0] addr, // Bank bits and in-bank offset
  output region_t region,              // Decoded region
  output logic [IDX_W-1:0] index       // Scratch store index
);

  logic [BANK_W-1:0] bank;
  logic [DIR_W-1:0] off;

  assign bank = addr[DADDR_W-1:DIR_W];
  assign off = addr[DIR_W-1:0];

  always_comb begin
    region = REGION_NONE;
    index = '0;
    if (off <= CTRL_TOP) begin
      region = REGION_CTRL;
    end else if (bank == BANK0 || (bank == BANK1 && off >= MIRROR_LO)) begin
      // The bank 1 top window shares storage with bank 0.
      if (!SMALL_VARIANT) begin
        region = REGION_SCRATCH;
        index = off - LARGE_B0_LO;
      end else if (off >= SMALL_B0_LO) begin
        region = REGION_SCRATCH;
        index = off - SMALL_B0_LO;
      end
    end else if (bank == BANK1 && !SMALL_VARIANT && off <= B1_SCR_HI) begin
      region = REGION_SCRATCH;
      index = off - B1_SCR_LO + B1_SCR_BASE;
    end
  end

endmodule
`default_nettype wire

//--- mem_map_pkg.sv
// Shared constants and carrier types for the program and data memory map.
// Assumes a single core clock and a core that owns the control registers.
package mem_map_pkg;

  // ----------------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------------
  localparam int PC_W = 13;
  localparam int PHYS_W = 11;
  localparam int SMALL_PHYS_W = 10;
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0] INTR_VEC = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int DADDR_W = 9;
  localparam int DIR_W = 7;
  localparam int BANK_W = 2;
  localparam int IDX_W = 7;
  localparam int LARGE_DEPTH = 128;
  localparam int SMALL_DEPTH = 64;
  localparam logic [BANK_W-1:0] BANK0 = 2'h0;
  localparam logic [BANK_W-1:0] BANK1 = 2'h1;
  localparam logic [DIR_W-1:0] CTRL_TOP = 7'h1f;
  localparam logic [DIR_W-1:0] LARGE_B0_LO = 7'h20;
  localparam logic [DIR_W-1:0] SMALL_B0_LO = 7'h40;
  localparam logic [DIR_W-1:0] B1_SCR_LO = 7'h20;
  localparam logic [DIR_W-1:0] B1_SCR_HI = 7'h3f;
  localparam logic [IDX_W-1:0] B1_SCR_BASE = 7'h60;
  localparam logic [DIR_W-1:0] MIRROR_LO = 7'h70;
  localparam logic [DATA_W-1:0] UNIMPL_DATA = 8'h00;

  typedef enum logic [1:0] {
    REGION_CTRL,
    REGION_SCRATCH,
    REGION_NONE
  } region_t;

  typedef struct packed {
    logic intr_take;
    logic load;
    logic [PC_W-1:0] load_addr;
    logic advance;
  } pc_ctl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic [DIR_W-1:0] dir_addr;
    logic [DATA_W-1:0] wdata;
  } data_req_t;

  typedef struct packed {
    logic valid;
    logic is_ctrl;
    logic [DATA_W-1:0] rdata;
  } data_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ctrl_acc_t;

endpackage

//--- prog_addr_wrap.sv
// Folds the program counter onto the implemented program store.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module prog_addr_wrap
  import mem_map_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic [PC_W-1:0] pc_in, // Program counter value
  output logic [PHYS_W-1:0] phys     // Implemented store address
);

  // Upper counter bits are dropped, so any address lands in the first 2K.
  always_comb begin
    if (SMALL_VARIANT) begin
      phys = {1'b0, pc_in[SMALL_PHYS_W-1:0]};
    end else begin
      phys = pc_in[PHYS_W-1:0];
    end
  end

endmodule
`default_nettype wire

//--- program_data_memory_map.sv
// Program counter with vector handling, and data memory map with the
// scratch store, mirrored window and control register forwarding.
// Assumes the core owns the control registers, the bank bits and the
// indirect pointer, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Program counter is 13 bits, addressing an 8K by 14 space.
// - Only 1K (small) or 2K (large) program words are implemented.
// - Fetches above the implemented range wrap into the first 1K (small) or 2K (large).
// - Fetch starts at address zero after reset.
// - Taking an interrupt loads the counter with 0004h.
// - The lowest 32 locations of every bank are control registers.
// - Large: bank 0 20h-7Fh and bank 1 A0h-BFh are scratch RAM.
// - Small: scratch RAM sits only at 40h-7Fh.
// - Bank 1 F0h-FFh reaches the same storage as bank 0 70h-7Fh.
// - Unimplemented locations read zero and ignore writes.
// - Bank bits, high then low, select banks 0 to 3.
// - Scratch RAM holds 64 bytes small, 128 bytes large.
// - Every location is reachable directly and through the pointer.
module program_data_memory_map
  import mem_map_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic clk_sys,                // Core clock
  input wire logic nrst,                   // Synchronous reset, active low
  input wire pc_ctl_t pc_ctl,              // Counter control from the core
  input wire logic bank_select_high,       // Upper bank bit
  input wire logic bank_select_low,        // Lower bank bit
  input wire logic [DATA_W-1:0] indirect_pointer, // Pointer register
  input wire data_req_t req,               // Data access request
  output logic [PC_W-1:0] pc,              // Program counter
  output logic [PHYS_W-1:0] fetch_addr,    // Implemented fetch address
  output data_rsp_t rsp,                   // Data access answer
  output ctrl_acc_t special_control_regs   // Forwarded control access
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int DEPTH = SMALL_VARIANT ? SMALL_DEPTH : LARGE_DEPTH;

  // The store is sized for the large part; the small decode never
  // produces an index past its 64 bytes, so the upper half stays idle.
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PHYS_W-1:0] fetch;
    data_rsp_t rsp;
    ctrl_acc_t ctrl;
    logic [LARGE_DEPTH-1:0][DATA_W-1:0] ram;
  } state_t;

  state_t st;
  state_t next_st;

  logic [PC_W-1:0] next_pc;
  logic [PHYS_W-1:0] next_phys;
  logic [DADDR_W-1:0] full_addr;
  region_t region;
  logic [IDX_W-1:0] index;

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  // Interrupt entry wins over a jump, and a jump over a plain step.
  always_comb begin
    if (pc_ctl.intr_take) begin
      next_pc = INTR_VEC;
    end else if (pc_ctl.load) begin
      next_pc = pc_ctl.load_addr;
    end else if (pc_ctl.advance) begin
      next_pc = st.pc + PC_STEP;
    end else begin
      next_pc = st.pc;
    end
  end

  prog_addr_wrap #(
    .SMALL_VARIANT(SMALL_VARIANT)
  ) u_wrap (
    .pc_in(next_pc),
    .phys(next_phys)
  );

  // ----------------------------------------------------------------------
  // Data address formation and decode
  // ----------------------------------------------------------------------
  // The indirect path takes its ninth bit from the upper bank bit.
  always_comb begin
    if (req.indirect) begin
      full_addr = {bank_select_high, indirect_pointer};
    end else begin
      full_addr = {bank_select_high, bank_select_low, req.dir_addr};
    end
  end

  data_addr_decode #(
    .SMALL_VARIANT(SMALL_VARIANT)
  ) u_decode (
    .addr(full_addr),
    .region(region),
    .index(index)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pc = next_pc;
    next_st.fetch = next_phys;
    next_st.rsp = '0;
    next_st.ctrl = '0;
    if (req.valid) begin
      next_st.rsp.valid = 1'b1;
      case (region)
        REGION_CTRL: begin
          // The core answers with its own register value.
          next_st.rsp.is_ctrl = 1'b1;
          next_st.ctrl.valid = 1'b1;
          next_st.ctrl.write = req.write;
          next_st.ctrl.addr = full_addr;
          next_st.ctrl.wdata = req.wdata;
        end
        REGION_SCRATCH: begin
          if (req.write) begin
            next_st.ram[index] = req.wdata;
          end else begin
            next_st.rsp.rdata = st.ram[index];
          end
        end
        default: begin
          next_st.rsp.rdata = UNIMPL_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
      st.pc <= RESET_VEC;
    end else begin
      st <= next_st;
    end
  end

  assign pc = st.pc;
  assign fetch_addr = st.fetch;
  assign rsp = st.rsp;
  assign special_control_regs = st.ctrl;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic [DIR_W-1:0] req_off;
  assign req_off = req.dir_addr;

  sequence s_write_low_mirror;
    req.valid && req.write && !req.indirect && req_off >= MIRROR_LO &&
      !bank_select_high && !bank_select_low;
  endsequence

  sequence s_read_high_mirror;
    req.valid && !req.write && !req.indirect && req_off == $past(req_off) &&
      !bank_select_high && bank_select_low;
  endsequence

  a_reset_vector: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !nrst |=> pc == RESET_VEC && fetch_addr == '0)
    else $error("counter not at reset vector after reset");

  a_intr_vector: assert property (
    pc_ctl.intr_take |=> pc == INTR_VEC &&
      fetch_addr == INTR_VEC[PHYS_W-1:0])
    else $error("interrupt did not load the vector");

  a_pc_advance: assert property (
    pc_ctl.advance && !pc_ctl.intr_take && !pc_ctl.load |=>
      pc == $past(pc) + PC_STEP)
    else $error("counter did not step by one");

  a_fetch_wrap: assert property (
    SMALL_VARIANT ? fetch_addr == {1'b0, pc[SMALL_PHYS_W-1:0]}
                  : fetch_addr == pc[PHYS_W-1:0])
    else $error("fetch address not folded from counter");

  a_ctrl_route: assert property (
    req.valid && !req.indirect && req_off <= CTRL_TOP |=>
      special_control_regs.valid && rsp.is_ctrl)
    else $error("low location not sent to control registers");

  a_bank_join: assert property (
    req.valid && !req.indirect && req_off <= CTRL_TOP |=>
      special_control_regs.addr ==
        {$past(bank_select_high), $past(bank_select_low), $past(req_off)})
    else $error("bank bits not joined to direct address");

  a_unimpl_zero: assert property (
    req.valid && !req.write && !req.indirect && bank_select_high &&
      req_off > CTRL_TOP |=> rsp.valid && rsp.rdata == UNIMPL_DATA &&
      !rsp.is_ctrl)
    else $error("unimplemented location did not read zero");

  a_mirror_shared: assert property (
    s_write_low_mirror ##1 s_read_high_mirror |=>
      rsp.rdata == $past(req.wdata, 2))
    else $error("mirror window does not share bank 0 storage");

  a_indirect_ctrl: assert property (
    req.valid && req.indirect && indirect_pointer[DIR_W-1:0] <= CTRL_TOP
      |=> special_control_regs.addr ==
        {$past(bank_select_high), $past(indirect_pointer)})
    else $error("pointer access reached wrong location");

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the memory map, large and small variants side
// by side. Assumes the core model only watches the large instance.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mem_map_pkg::*;
;
  typedef struct packed {
    logic [1:0] bk;
    logic ind;
    logic [7:0] a;
    logic wr;
    logic [7:0] wd;
    logic ctl;
    logic [7:0] exl;
    logic [7:0] exs;
  } row_t;
  logic clk_sys, nrst, bsh, bsl;
  pc_ctl_t pc_ctl;
  data_req_t req;
  logic [7:0] ptr;
  logic [PC_W-1:0] pc_l, pc_s;
  logic [PHYS_W-1:0] fa_l, fa_s;
  data_rsp_t rsp_l, rsp_s;
  ctrl_acc_t ca_l;
  logic [DADDR_W-1:0] m_addr;
  logic [DATA_W-1:0] m_wd;
  int n_fail = 0, checks = 0, cyc = 0;
  row_t rows [20] = '{
    '{2'h0,1'h0,8'h20,1'h1,8'ha5,1'h0,8'h00,8'h00},
    '{2'h0,1'h0,8'h20,1'h0,8'h00,1'h0,8'ha5,8'h00},
    '{2'h1,1'h0,8'h75,1'h1,8'h3c,1'h0,8'h00,8'h00},
    '{2'h0,1'h0,8'h75,1'h0,8'h00,1'h0,8'h3c,8'h3c},
    '{2'h1,1'h0,8'h20,1'h1,8'h5a,1'h0,8'h00,8'h00},
    '{2'h1,1'h0,8'h20,1'h0,8'h00,1'h0,8'h5a,8'h00},
    '{2'h0,1'h0,8'h3f,1'h1,8'h99,1'h0,8'h00,8'h00},
    '{2'h0,1'h0,8'h3f,1'h0,8'h00,1'h0,8'h99,8'h00},
    '{2'h0,1'h0,8'h40,1'h1,8'h11,1'h0,8'h00,8'h00},
    '{2'h0,1'h0,8'h40,1'h0,8'h00,1'h0,8'h11,8'h11},
    '{2'h1,1'h0,8'h40,1'h1,8'h77,1'h0,8'h00,8'h00},
    '{2'h1,1'h0,8'h40,1'h0,8'h00,1'h0,8'h00,8'h00},
    '{2'h2,1'h0,8'h20,1'h1,8'hff,1'h0,8'h00,8'h00},
    '{2'h2,1'h0,8'h20,1'h0,8'h00,1'h0,8'h00,8'h00},
    '{2'h0,1'h0,8'h20,1'h0,8'h00,1'h0,8'ha5,8'h00},
    '{2'h3,1'h0,8'h03,1'h0,8'h00,1'h1,8'h00,8'h00},
    '{2'h1,1'h0,8'h1f,1'h0,8'h00,1'h1,8'h00,8'h00},
    '{2'h0,1'h1,8'ha0,1'h0,8'h00,1'h0,8'h5a,8'h00},
    '{2'h0,1'h1,8'hf5,1'h0,8'h00,1'h0,8'h3c,8'h3c},
    '{2'h0,1'h1,8'h04,1'h0,8'h00,1'h1,8'h00,8'h00}};

  program_data_memory_map #(.SMALL_VARIANT(1'b0)) dut_u (.clk_sys(clk_sys),
    .nrst(nrst), .pc_ctl(pc_ctl), .bank_select_high(bsh),
    .bank_select_low(bsl), .indirect_pointer(ptr), .req(req), .pc(pc_l),
    .fetch_addr(fa_l), .rsp(rsp_l), .special_control_regs(ca_l));
  program_data_memory_map #(.SMALL_VARIANT(1'b1)) dut_s (.clk_sys(clk_sys),
    .nrst(nrst), .pc_ctl(pc_ctl), .bank_select_high(bsh),
    .bank_select_low(bsl), .indirect_pointer(ptr), .req(req), .pc(pc_s),
    .fetch_addr(fa_s), .rsp(rsp_s), .special_control_regs());
  core_ctrl_model core_u (.clk_sys(clk_sys), .nrst(nrst), .acc(ca_l),
    .last_addr(m_addr), .last_wdata(m_wd));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // The command is held for exactly one edge, then the new count is read.
  task automatic pc_cmd(logic i, logic l, logic [12:0] a, logic adv);
    @(posedge clk_sys);
    pc_ctl <= {i, l, a, adv};
    @(posedge clk_sys);
    pc_ctl <= '0;
    #1;
  endtask
  task automatic acc(row_t r);
    @(posedge clk_sys);
    {bsh, bsl} <= r.bk;
    ptr <= r.a;
    req <= {1'b1, r.wr, r.ind, r.a[6:0], r.wd};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    bsh = 1'b0;
    bsl = 1'b0;
    ptr = '0;
    pc_ctl = '0;
    req = '0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk("pc after reset", pc_l, 16'h0000);
    foreach (rows[i]) begin
      acc(rows[i]);
      chk("valid", rsp_l.valid, 16'h0001);
      chk("ctrl", rsp_l.is_ctrl, rows[i].ctl);
      chk("fwd", ca_l.valid, rows[i].ctl);
      chk("large", rsp_l.rdata, rows[i].exl);
      chk("small", rsp_s.rdata, rows[i].exs);
      if (rows[i].ctl) begin
        @(posedge clk_sys);
        #1;
        chk("ctl addr", m_addr, rows[i].ind ? {rows[i].bk[1], rows[i].a}
          : {rows[i].bk, rows[i].a[6:0]});
      end
    end
    pc_cmd(1'b0, 1'b0, 13'h0000, 1'b1);
    chk("advance", pc_l, 16'h0001);
    pc_cmd(1'b0, 1'b1, 13'h07ff, 1'b1);
    chk("fetch top", fa_l, 16'h07ff);
    chk("fetch small", fa_s, 16'h03ff);
    pc_cmd(1'b0, 1'b1, 13'h1805, 1'b0);
    chk("pc wide", pc_l, 16'h1805);
    chk("wrap", fa_l, 16'h0005);
    chk("wrap small", fa_s, 16'h0005);
    pc_cmd(1'b1, 1'b1, 13'h0123, 1'b1);
    chk("vector", pc_l, 16'h0004);
    chk("vec fetch", fa_s, 16'h0004);
    chk("vec small", pc_s, 16'h0004);
    pc_cmd(1'b0, 1'b1, 13'h1fff, 1'b0);
    pc_cmd(1'b0, 1'b0, 13'h0000, 1'b1);
    chk("pc roll", pc_l, 16'h0000);
    // Back-to-back write low window then read high window, so that the
    // mirror assertion sees its antecedent.
    @(posedge clk_sys);
    {bsh, bsl} <= 2'b00;
    req <= {1'b1, 1'b1, 1'b0, 7'h7a, 8'hc3};
    @(posedge clk_sys);
    bsl <= 1'b1;
    req <= {1'b1, 1'b0, 1'b0, 7'h7a, 8'h00};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk("mirror b2b", rsp_l.rdata, 16'h00c3);
    chk("mirror b2b small", rsp_s.rdata, 16'h00c3);
    acc('{2'h0, 1'h0, 8'h05, 1'h1, 8'h6b, 1'h1, 8'h00, 8'h00});
    chk("ctl write", ca_l.write, 16'h0001);
    @(posedge clk_sys);
    #1;
    chk("ctl wdata", m_wd, 16'h006b);
    chk("ctl waddr", m_addr, 16'h0005);
    pc_cmd(1'b0, 1'b1, 13'h0100, 1'b0);
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk("pc reset", pc_l, 16'h0000);
    acc(rows[1]);
    chk("cleared", rsp_l.rdata, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
